// ### design/amcr_regs.sv
`timescale 1ns/100ps
module amcr_regs
  import amcr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  amcr_req_t        req,
  output logic [7:0]       rdata,
  output logic             rvalid,
  input  wire logic [1:0]  power_state_code,
  input  wire logic        left_mute_in,
  input  wire logic        right_mute_in,
  input  wire logic        clock_invalid_in,
  input  wire logic        fault_in_n,
  output amcr_ctrl_t       ctrl,
  output logic             flag_pin_out,
  output logic             flag_pin_oe
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] gain_reg;
  logic [7:0] bq_mark_reg;
  logic [7:0] dac_reg;
  logic [7:0] pin_dir_reg;
  logic [7:0] pin_src_reg;
  logic [7:0] bypass_reg;
  logic [7:0] phase_reg;
  logic [7:0] pwr_reg;
  logic [7:0] mute_reg;
  logic [7:0] rdata_next;

  // ------------------------------------------------------------
  // synchronised status inputs
  // ------------------------------------------------------------
  logic [3:0]  stat_async;
  logic [3:0]  stat_sync;
  logic [1:0]  pwr_sync;
  amcr_flags_t flags;

  assign stat_async = {left_mute_in, right_mute_in,
                       clock_invalid_in, fault_in_n};

  amcr_sync2 #(.W(4)) u_stat_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (stat_async),
    .sync_out (stat_sync)
  );

  amcr_sync2 #(.W(2)) u_pwr_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (power_state_code),
    .sync_out (pwr_sync)
  );

  assign flags = stat_sync;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire wr_gain    = req.wr_en && (req.addr == AMCR_OFS_GAIN);
  wire wr_bq_mark = req.wr_en && (req.addr == AMCR_OFS_BQ_MARK);
  wire wr_dac     = req.wr_en && (req.addr == AMCR_OFS_DAC);
  wire wr_pin_dir = req.wr_en && (req.addr == AMCR_OFS_PIN_DIR);
  wire wr_pin_src = req.wr_en && (req.addr == AMCR_OFS_PIN_SRC);
  wire wr_bypass  = req.wr_en && (req.addr == AMCR_OFS_BYPASS);
  wire wr_phase   = req.wr_en && (req.addr == AMCR_OFS_PHASE);

  // ------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg    <= AMCR_RST_GAIN;
      bq_mark_reg <= AMCR_RST_BQ_MARK;
      dac_reg     <= AMCR_RST_DAC;
      pin_dir_reg <= AMCR_RST_PIN_DIR;
      pin_src_reg <= AMCR_RST_PIN_SRC;
      bypass_reg  <= AMCR_RST_BYPASS;
      phase_reg   <= AMCR_RST_PHASE;
    end else begin
      if (wr_gain)    gain_reg    <= req.wdata & AMCR_MSK_GAIN;
      if (wr_bq_mark) bq_mark_reg <= req.wdata & AMCR_MSK_BQ_MARK;
      if (wr_dac)     dac_reg     <= req.wdata;
      if (wr_pin_dir) pin_dir_reg <= req.wdata & AMCR_MSK_PIN_DIR;
      if (wr_pin_src) pin_src_reg <= req.wdata & AMCR_MSK_PIN_SRC;
      if (wr_bypass)  bypass_reg  <= req.wdata & AMCR_MSK_BYPASS;
      if (wr_phase)   phase_reg   <= req.wdata & AMCR_MSK_PHASE;
    end
  end

  // ------------------------------------------------------------
  // status registers, hardware only
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg  <= AMCR_RST_PWR;
      mute_reg <= AMCR_RST_MUTE;
    end else begin
      pwr_reg  <= {6'h00, pwr_sync};
      mute_reg <= {6'h00, flags.right_silence_muted,
                   flags.left_silence_muted};
    end
  end

  // ------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------
  assign ctrl.output_attenuation_code  = gain_reg[4:0];
  assign ctrl.filter_coef_start_marker = bq_mark_reg[0];
  assign ctrl.mod_freq_slow    = dac_reg[AMCR_DAC_FREQ_BIT];
  assign ctrl.dither_main_en   = dac_reg[AMCR_DAC_DITH_EN_LO];
  assign ctrl.dither_second_en = dac_reg[AMCR_DAC_DITH_EN_HI];
  assign ctrl.dither_level     =
    dac_reg[AMCR_DAC_DITH_HI:AMCR_DAC_DITH_LO];
  assign ctrl.element_matching_select = dac_reg[AMCR_DAC_DEM_HI:0];
  assign ctrl.coef_unique = bypass_reg[AMCR_BYP_UNIQUE_BIT];
  assign ctrl.fir_bypass  = bypass_reg[AMCR_BYP_FIR_BIT];
  assign ctrl.drc_bypass  = bypass_reg[AMCR_BYP_DRC_BIT];
  assign ctrl.eq_bypass   = bypass_reg[AMCR_BYP_EQ_BIT];
  assign ctrl.pwm_phase   = phase_reg[3:0];

  // ------------------------------------------------------------
  // flag pin
  // ------------------------------------------------------------
  amcr_pin_mux u_pin_mux (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .src_code   (pin_src_reg[4:0]),
    .pin_oe_bit (pin_dir_reg[0]),
    .flags      (flags),
    .pin_out    (flag_pin_out),
    .pin_oe     (flag_pin_oe)
  );

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    case (req.addr)
      AMCR_OFS_GAIN:    rdata_next = gain_reg;
      AMCR_OFS_BQ_MARK: rdata_next = bq_mark_reg;
      AMCR_OFS_DAC:     rdata_next = dac_reg;
      AMCR_OFS_PIN_DIR: rdata_next = pin_dir_reg;
      AMCR_OFS_PIN_SRC: rdata_next = pin_src_reg;
      AMCR_OFS_BYPASS:  rdata_next = bypass_reg;
      AMCR_OFS_SILICON_ID_VALUE:  rdata_next = AMCR_SILICON_ID;
      AMCR_OFS_PWR:     rdata_next = pwr_reg;
      AMCR_OFS_MUTE:    rdata_next = mute_reg;
      AMCR_OFS_PHASE:   rdata_next = phase_reg;
      default:          rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd_en;
      if (req.rd_en) rdata <= rdata_next;
    end
  end

endmodule : amcr_regs

// ### design/amcr_pkg.sv
package amcr_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] AMCR_OFS_GAIN     = 8'h54;
  localparam logic [7:0] AMCR_OFS_BQ_MARK  = 8'h5C;
  localparam logic [7:0] AMCR_OFS_DAC      = 8'h5D;
  localparam logic [7:0] AMCR_OFS_PIN_DIR  = 8'h60;
  localparam logic [7:0] AMCR_OFS_PIN_SRC  = 8'h61;
  localparam logic [7:0] AMCR_OFS_BYPASS   = 8'h66;
  localparam logic [7:0] AMCR_OFS_SILICON_ID_VALUE   = 8'h67;
  localparam logic [7:0] AMCR_OFS_PWR      = 8'h68;
  localparam logic [7:0] AMCR_OFS_MUTE     = 8'h69;
  localparam logic [7:0] AMCR_OFS_PHASE    = 8'h6A;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] AMCR_RST_GAIN     = 8'h00;
  localparam logic [7:0] AMCR_RST_BQ_MARK  = 8'h00;
  localparam logic [7:0] AMCR_RST_DAC      = 8'hF8;
  localparam logic [7:0] AMCR_RST_PIN_DIR  = 8'h00;
  localparam logic [7:0] AMCR_RST_PIN_SRC  = 8'h00;
  localparam logic [7:0] AMCR_RST_BYPASS   = 8'h00;
  localparam logic [7:0] AMCR_RST_PWR      = 8'h00;
  localparam logic [7:0] AMCR_RST_MUTE     = 8'h00;
  localparam logic [7:0] AMCR_RST_PHASE    = 8'h00;

  // writable bit masks (reserved bits read zero)
  localparam logic [7:0] AMCR_MSK_GAIN     = 8'h1F;
  localparam logic [7:0] AMCR_MSK_BQ_MARK  = 8'h01;
  localparam logic [7:0] AMCR_MSK_PIN_DIR  = 8'h01;
  localparam logic [7:0] AMCR_MSK_PIN_SRC  = 8'h1F;
  localparam logic [7:0] AMCR_MSK_BYPASS   = 8'h0F;
  localparam logic [7:0] AMCR_MSK_PHASE    = 8'h0F;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int AMCR_DAC_FREQ_BIT   = 7;
  localparam int AMCR_DAC_DITH_EN_HI = 6;
  localparam int AMCR_DAC_DITH_EN_LO = 5;
  localparam int AMCR_DAC_DITH_HI    = 4;
  localparam int AMCR_DAC_DITH_LO    = 2;
  localparam int AMCR_DAC_DEM_HI     = 1;
  localparam int AMCR_BYP_UNIQUE_BIT = 3;
  localparam int AMCR_BYP_FIR_BIT    = 2;
  localparam int AMCR_BYP_DRC_BIT    = 1;
  localparam int AMCR_BYP_EQ_BIT     = 0;
  localparam int AMCR_MUTE_R_BIT     = 1;
  localparam int AMCR_MUTE_L_BIT     = 0;

  // ------------------------------------------------------------
  // flag pin source codes
  // ------------------------------------------------------------
  localparam logic [4:0] AMCR_SRC_LOW     = 5'h00;
  localparam logic [4:0] AMCR_SRC_BOTH    = 5'h03;
  localparam logic [4:0] AMCR_SRC_LEFT    = 5'h04;
  localparam logic [4:0] AMCR_SRC_RIGHT   = 5'h05;
  localparam logic [4:0] AMCR_SRC_CLKBAD  = 5'h06;
  localparam logic [4:0] AMCR_SRC_FAULT   = 5'h0B;

  // arbitrary neutral silicon id value
  localparam logic [7:0] AMCR_SILICON_ID  = 8'h5A;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amcr_req_t;

  typedef struct packed {
    logic [4:0] output_attenuation_code;
    logic       filter_coef_start_marker;
    logic       mod_freq_slow;
    logic       dither_main_en;
    logic       dither_second_en;
    logic [2:0] dither_level;
    logic [1:0] element_matching_select;
    logic       coef_unique;
    logic       fir_bypass;
    logic       drc_bypass;
    logic       eq_bypass;
    logic [3:0] pwm_phase;
  } amcr_ctrl_t;

  typedef struct packed {
    logic       left_silence_muted;
    logic       right_silence_muted;
    logic       clock_invalid;
    logic       fault_indication_n;
  } amcr_flags_t;

endpackage : amcr_pkg

// ### design/amcr_sync2.sv
`timescale 1ns/100ps
module amcr_sync2 #(
  parameter int W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule : amcr_sync2

// ### design/amcr_pin_mux.sv
`timescale 1ns/100ps
module amcr_pin_mux
  import amcr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  src_code,
  input  wire logic        pin_oe_bit,
  input  amcr_flags_t      flags,
  output logic             pin_out,
  output logic             pin_oe
);
  logic sel_level;

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  always_comb begin
    case (src_code)
      AMCR_SRC_LOW:    sel_level = 1'b0;
      AMCR_SRC_BOTH:   sel_level = flags.left_silence_muted &
                                   flags.right_silence_muted;
      AMCR_SRC_LEFT:   sel_level = flags.left_silence_muted;
      AMCR_SRC_RIGHT:  sel_level = flags.right_silence_muted;
      AMCR_SRC_CLKBAD: sel_level = flags.clock_invalid;
      AMCR_SRC_FAULT:  sel_level = flags.fault_indication_n;
      default:         sel_level = 1'b0;  // reserved codes drive low
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= sel_level;
      pin_oe  <= pin_oe_bit;
    end
  end
endmodule : amcr_pin_mux

// ### tb/amcr_monitor.sv
`timescale 1ns/100ps
module amcr_monitor
  import amcr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  amcr_req_t       req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  input  wire logic [1:0] power_state_code,
  input  wire logic       left_mute_in,
  input  wire logic       right_mute_in,
  input  wire logic       clock_invalid_in,
  input  wire logic       fault_in_n,
  input  amcr_ctrl_t      ctrl,
  input  wire logic       flag_pin_out,
  input  wire logic       flag_pin_oe
);
  // ----
  // shadow of the pin source code
  // ----
  logic [4:0] src_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      src_q <= 5'h00;
    else if (req.wr_en && req.addr == AMCR_OFS_PIN_SRC)
      src_q <= req.wdata[4:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_to(logic [7:0] a);
    req.wr_en && req.addr == a;
  endsequence
  sequence mute_settled;
    ($stable(left_mute_in) && $stable(right_mute_in))[*5];
  endsequence
  property follows(logic [4:0] c, logic s);
    (src_q == c && $stable(s))[*5] |-> flag_pin_out == s;
  endproperty
  gain_write_a: assert property (wr_to(AMCR_OFS_GAIN) |=>
    ctrl.output_attenuation_code == $past(req.wdata[4:0]))
    else $error("gain code not taken");
  marker_write_a: assert property (wr_to(AMCR_OFS_BQ_MARK) |=>
    ctrl.filter_coef_start_marker == $past(req.wdata[0]))
    else $error("marker not taken");
  dac_write_a: assert property (wr_to(AMCR_OFS_DAC) |=>
    {ctrl.mod_freq_slow, ctrl.dither_second_en, ctrl.dither_main_en,
     ctrl.dither_level, ctrl.element_matching_select} == $past(req.wdata))
    else $error("modulator fields wrong");
  bypass_write_a: assert property (wr_to(AMCR_OFS_BYPASS) |=>
    {ctrl.coef_unique, ctrl.fir_bypass, ctrl.drc_bypass, ctrl.eq_bypass}
    == $past(req.wdata[3:0])) else $error("bypass fields wrong");
  pin_dir_a: assert property (wr_to(AMCR_OFS_PIN_DIR) |=> ##1
    flag_pin_oe == $past(req.wdata[0], 2)) else $error("pin direction wrong");
  pin_low_a: assert property ((src_q inside {5'h00, 5'h07, 5'h09})[*2]
    |-> !flag_pin_out) else $error("pin not low");
  both_pin_a: assert property (follows(AMCR_SRC_BOTH,
    left_mute_in && right_mute_in)) else $error("both mute flag wrong");
  left_pin_a: assert property (follows(AMCR_SRC_LEFT, left_mute_in))
    else $error("left mute flag wrong");
  right_pin_a: assert property (follows(AMCR_SRC_RIGHT, right_mute_in))
    else $error("right mute flag wrong");
  clkbad_pin_a: assert property (follows(AMCR_SRC_CLKBAD, clock_invalid_in))
    else $error("clock flag wrong");
  fault_pin_a: assert property (follows(AMCR_SRC_FAULT, fault_in_n))
    else $error("fault output wrong");
  mute_read_a: assert property (mute_settled ##0
    (req.rd_en && req.addr == AMCR_OFS_MUTE) |=> rdata ==
    {6'h00, $past(right_mute_in), $past(left_mute_in)}) else $error("mute read");
  read_strobe_a: assert property (rvalid == $past(req.rd_en))
    else $error("read strobe wrong");
endmodule : amcr_monitor

bind amcr_regs amcr_monitor u_amcr_monitor (.sys_clk, .rst_n, .req, .rdata,
  .rvalid, .power_state_code, .left_mute_in, .right_mute_in,
  .clock_invalid_in, .fault_in_n, .ctrl, .flag_pin_out, .flag_pin_oe);

// ### tb/amcr_host.sv
`timescale 1ns/100ps
module amcr_host
  import amcr_pkg::*;
(
  input  wire logic       sys_clk,
  output amcr_req_t       req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{1'b0, 1'b1, a, 8'hA5};
    @(posedge sys_clk);
    req <= '{1'b0, 1'b0, ~a, 8'h5A};
    @(posedge sys_clk);
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask : rd
endmodule : amcr_host

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
  import amcr_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  amcr_req_t  req;
  logic [7:0] rdata;
  logic       rvalid;
  logic [1:0] power_state_code = 2'h0;
  logic       left_mute_in = 1'b0;
  logic       right_mute_in = 1'b0;
  logic       clock_invalid_in = 1'b0;
  logic       fault_in_n = 1'b1;
  amcr_ctrl_t ctrl;
  logic       flag_pin_out;
  logic       flag_pin_oe;
  int         err_total = 0;
  int         checks = 0;
  int         cyc = 0;
  logic [7:0] ofs [10] = '{8'h54, 8'h5C, 8'h5D, 8'h60, 8'h61, 8'h66,
                           8'h67, 8'h68, 8'h69, 8'h6A};
  logic [7:0] rstv [10] = '{8'h00, 8'h00, 8'hF8, 8'h00, 8'h00, 8'h00,
                            AMCR_SILICON_ID, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [10] = '{8'h1F, 8'h01, 8'hFF, 8'h01, 8'h1F, 8'h0F,
                           8'h00, 8'h00, 8'h00, 8'h0F};
  logic [4:0] codes [8] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
                            5'h09, 5'h0B};
  always #10 sys_clk = ~sys_clk;
  amcr_regs u_amcr_regs (.sys_clk, .rst_n, .req, .rdata, .rvalid,
    .power_state_code, .left_mute_in, .right_mute_in, .clock_invalid_in,
    .fault_in_n, .ctrl, .flag_pin_out, .flag_pin_oe);
  amcr_host u_amcr_host (.sys_clk, .req, .rdata, .rvalid);
  // ----
  // checking and closing
  // ----
  task automatic end_of_test;
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_amcr_host.rd(a, d);
    chk(d, exp);
  endtask : rd_chk
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      end_of_test();
    end
  end
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    power_state_code <= 2'h0;
    left_mute_in <= 1'b0;
    right_mute_in <= 1'b0;
    clock_invalid_in <= 1'b0;
    fault_in_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : t_reset
  task automatic t_reset_values;
    for (int i = 0; i < 10; i++)
      rd_chk(ofs[i], rstv[i]);
    rd_chk(8'h55, 8'h00);
    chk({7'h00, flag_pin_oe}, 8'h00);
    chk({ctrl.mod_freq_slow, ctrl.dither_second_en, ctrl.dither_main_en,
         ctrl.dither_level, ctrl.element_matching_select},
        AMCR_RST_DAC);
  endtask : t_reset_values
  task automatic t_writable;
    for (int i = 0; i < 10; i++) begin
      if (msk[i] != 8'h00) begin
        u_amcr_host.wr(ofs[i], 8'hFF);
        rd_chk(ofs[i], msk[i]);
        u_amcr_host.wr(ofs[i], 8'h00);
        rd_chk(ofs[i], 8'h00);
      end
    end
    for (int k = 0; k < 32; k++) begin
      u_amcr_host.wr(AMCR_OFS_GAIN, 8'(k));
      u_amcr_host.wr(AMCR_OFS_DAC, 8'(k) << 2);
      chk({3'h0, ctrl.output_attenuation_code}, 8'(k));
      chk({3'h0, ctrl.dither_second_en, ctrl.dither_main_en,
           ctrl.dither_level}, 8'(k));
    end
    u_amcr_host.wr(AMCR_OFS_BYPASS, 8'h0A);
    u_amcr_host.wr(AMCR_OFS_PHASE, 8'h05);
    u_amcr_host.wr(AMCR_OFS_BQ_MARK, 8'h01);
    chk({4'h0, ctrl.coef_unique, ctrl.fir_bypass, ctrl.drc_bypass,
         ctrl.eq_bypass}, 8'h0A);
    chk({4'h0, ctrl.pwm_phase}, 8'h05);
    chk({7'h00, ctrl.filter_coef_start_marker}, 8'h01);
    chk({7'h00, ctrl.mod_freq_slow}, 8'h00);
  endtask : t_writable
  task automatic t_readonly;
    for (int i = 6; i < 9; i++)
      u_amcr_host.wr(ofs[i], 8'hFF);
    u_amcr_host.wr(8'h70, 8'hFF);
    for (int i = 6; i < 9; i++)
      rd_chk(ofs[i], rstv[i]);
    rd_chk(8'h70, 8'h00);
  endtask : t_readonly
  task automatic t_status;
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      power_state_code <= 2'(k);
      left_mute_in <= k[0];
      right_mute_in <= k[1];
      repeat (6) @(posedge sys_clk);
      rd_chk(AMCR_OFS_PWR, 8'(k));
      rd_chk(AMCR_OFS_MUTE, 8'(k));
    end
  endtask : t_status
  task automatic t_pin;
    logic [3:0] f;
    logic       e;
    u_amcr_host.wr(AMCR_OFS_PIN_DIR, 8'h01);
    @(negedge sys_clk);
    chk({7'h00, flag_pin_oe}, 8'h01);
    for (int c = 0; c < 8; c++) begin
      u_amcr_host.wr(AMCR_OFS_PIN_SRC, {3'h0, codes[c]});
      for (int k = 0; k < 16; k++) begin
        f = 4'(k);
        @(posedge sys_clk);
        {fault_in_n, clock_invalid_in, right_mute_in, left_mute_in} <= f;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        case (codes[c])
          5'h03: e = f[0] & f[1];
          5'h04: e = f[0];
          5'h05: e = f[1];
          5'h06: e = f[2];
          5'h0B: e = f[3];
          default: e = 1'b0;
        endcase
        chk({7'h00, flag_pin_out}, {7'h00, e});
      end
    end
    u_amcr_host.wr(AMCR_OFS_PIN_DIR, 8'h00);
    @(negedge sys_clk);
    chk({7'h00, flag_pin_oe}, 8'h00);
  endtask : t_pin
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_writable();
    t_readonly();
    t_status();
    t_pin();
    t_reset();
    t_reset_values();
    end_of_test();
  end
endmodule : tb
